// File: pmc_pkg.sv
// constants, field positions and state types of the point-of-load config registers
package pmc_pkg;

  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_EXT_TEMP_GAIN = 8'hd9;
  localparam logic [7:0] CMD_EXT_TEMP_BIAS = 8'hda;
  localparam logic [7:0] CMD_OUT_CEILING = 8'hdb;
  localparam logic [7:0] CMD_SENSE_COEF = 8'hdc;
  localparam logic [7:0] CMD_GAP_TIMES = 8'hdd;
  localparam logic [7:0] CMD_GAP_SETUP = 8'hde;
  localparam logic [7:0] CMD_RAIL_ORDER = 8'he0;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int GAP_W = 8;
  localparam int GAP_HL_LSB = 8;
  localparam int GAP_LH_LSB = 0;
  localparam int MIN_W = 7;
  localparam int MIN_HL_LSB = 8;
  localparam int MIN_LH_LSB = 0;
  localparam int FREEZE_HL_BIT = 15;
  localparam int FREEZE_LH_BIT = 7;
  localparam int RAIL_ID_W = 5;
  localparam int RAIL_PRE_ID_LSB = 8;
  localparam int RAIL_SEQ_ID_LSB = 0;
  localparam int RAIL_PRE_EN_BIT = 15;
  localparam int RAIL_SEQ_EN_BIT = 7;

  // ------------------------------------------------------------
  // reset values and sizes
  // ------------------------------------------------------------
  localparam logic [7:0] GAP_MAX_DEFAULT_NS = 8'h3c;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] READ_PAD = 8'hff;
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20;

  // ------------------------------------------------------------
  // serial engine states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PMC_IDLE = 3'b000,
    PMC_RX = 3'b001,
    PMC_ACK = 3'b010,
    PMC_TX = 3'b011,
    PMC_MACK = 3'b100
  } pmc_state_e;

  typedef enum logic [1:0] {
    PMC_PH_ADDR = 2'b00,
    PMC_PH_CMD = 2'b01,
    PMC_PH_DATA = 2'b10
  } pmc_phase_e;

endpackage : pmc_pkg

// File: pmc_gap_resolve.sv
// one switching edge: picks the applied dead time from mode, limits and request
`timescale 1ns/10ps
module pmc_gap_resolve (
  input wire logic [7:0] gap_ns_i,
  input wire logic [6:0] min_code_i,
  input wire logic [7:0] max_ns_i,
  input wire logic freeze_i,
  input wire logic [7:0] adapt_ns_i,
  output logic [7:0] applied_ns_o
);

  logic signed [7:0] min_ns;

  // min code counts 2 ns steps, signed
  assign min_ns = $signed({min_code_i, 1'b0});

  // frozen edge runs on the stored word, else clamp the request
  always_comb
  begin
    applied_ns_o = adapt_ns_i;
    if (freeze_i)
    begin
      applied_ns_o = gap_ns_i;
    end
    else if ($signed(adapt_ns_i) < min_ns)
    begin
      applied_ns_o = min_ns;
    end
    else if ($signed(adapt_ns_i) > $signed(max_ns_i))
    begin
      applied_ns_o = max_ns_i;
    end
  end

endmodule : pmc_gap_resolve

// File: pmc_cfg_regs.sv
// serial-bus config command registers with dead-time and rail-order outputs
//
// What this block does
// - second temperature gain and bias words are only stored and read back
// - gain and bias stored, no functional effect
// - gain, bias kept as raw linear words
// - ceiling is read-only strapped word
// - coefficient byte is read/write unsigned
// - upper gap byte is signed high-to-low
// - lower gap byte is signed low-to-high
// - adaptive maximum defaults to sixty ns
// - gap then setup write sets new maximum
// - adaptive off uses the stored gap word
// - setup bits 14:8 limit high-to-low minimum
// - setup bits 6:0 limit low-to-high minimum
// - setup bit 15 freezes high-to-low edge
// - setup bit 7 freezes low-to-high edge
// - rail bits 12:8 name preceding rail
// - rail bits 4:0 name following rail
// - rail bit 15 enables preceding link
// - rail bit 7 enables following link
`timescale 1ns/10ps
module pmc_cfg_regs #(
  parameter logic [6:0] DEV_ADDR = pmc_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] strap_vout_max_i,
  input wire logic [7:0] adapt_hl_ns_i,
  input wire logic [7:0] adapt_lh_ns_i,
  output logic [7:0] dt_hl_ns_o,
  output logic [7:0] dt_lh_ns_o,
  output logic dt_hl_frozen_o,
  output logic dt_lh_frozen_o,
  output logic [7:0] sense_temp_coef_o,
  output logic prequel_en_o,
  output logic [4:0] prequel_id_o,
  output logic sequel_en_o,
  output logic [4:0] sequel_id_o
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  pmc_pkg::pmc_state_e state_r;
  pmc_pkg::pmc_phase_e phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shreg_r;
  logic rd_mode_r;
  logic cmd_have_r;
  logic [7:0] cmd_r;
  logic [1:0] byte_idx_r;
  logic [15:0] wbuf_r;
  logic sda_drive_r;
  logic ack_now;
  logic [15:0] rd_word;
  logic [7:0] tx_byte;
  logic [2:0] bit_sel;
  logic wr_commit;
  logic gap_pending_r;
  logic [1:0] strap_cnt_r;
  logic [15:0] strap_s1_r;
  logic [15:0] strap_s2_r;
  logic [15:0] ext_temp_gain_r;
  logic [15:0] ext_temp_bias_r;
  logic [15:0] strapped_output_ceiling_r;
  logic [7:0] sense_temp_coefficient_r;
  logic [15:0] switch_gap_times_r;
  logic [15:0] switch_gap_setup_r;
  logic [15:0] rail_order_links_r;
  logic [1:0][7:0] gap_max_r;
  logic [1:0][7:0] adapt_ns;
  logic [1:0][7:0] applied_nxt;
  logic [1:0][7:0] applied_r;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  function automatic logic [1:0] cmd_len(input logic [7:0] c);
    case (c)
      pmc_pkg::CMD_SENSE_COEF: cmd_len = pmc_pkg::LEN_BYTE;
      pmc_pkg::CMD_EXT_TEMP_GAIN,
      pmc_pkg::CMD_EXT_TEMP_BIAS,
      pmc_pkg::CMD_OUT_CEILING,
      pmc_pkg::CMD_GAP_TIMES,
      pmc_pkg::CMD_GAP_SETUP,
      pmc_pkg::CMD_RAIL_ORDER: cmd_len = pmc_pkg::LEN_WORD;
      default: cmd_len = pmc_pkg::LEN_NONE;
    endcase
  endfunction : cmd_len

  function automatic logic cmd_writable(input logic [7:0] c);
    cmd_writable = (cmd_len(c) != pmc_pkg::LEN_NONE) && (c != pmc_pkg::CMD_OUT_CEILING);
  endfunction : cmd_writable

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // two stages then a delay copy for edges
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      pin_d_r <= 2'h3;
    end
    else if (ce_i)
    begin
      pin_s1_r <= {scl_i, sda_i};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign scl_rise = pin_s2_r[1] & ~pin_d_r[1];
  assign scl_fall = ~pin_s2_r[1] & pin_d_r[1];
  assign start_det = pin_s2_r[1] & pin_d_r[1] & pin_d_r[0] & ~pin_s2_r[0];
  assign stop_det = pin_s2_r[1] & pin_d_r[1] & ~pin_d_r[0] & pin_s2_r[0];

  // ------------------------------------------------------------
  // serial engine
  // ------------------------------------------------------------
  // acknowledge decision at the end of a received byte
  always_comb
  begin
    ack_now = 1'b0;
    case (phase_r)
      pmc_pkg::PMC_PH_ADDR:
        ack_now = (shreg_r[7:1] == DEV_ADDR) &&
                  (!shreg_r[0] || (cmd_have_r && cmd_len(cmd_r) != pmc_pkg::LEN_NONE));
      pmc_pkg::PMC_PH_CMD:
        ack_now = cmd_len(shreg_r) != pmc_pkg::LEN_NONE;
      pmc_pkg::PMC_PH_DATA:
        ack_now = cmd_writable(cmd_r) && (byte_idx_r < cmd_len(cmd_r));
      default:
        ack_now = 1'b0;
    endcase
  end

  // read word select, low byte goes out first
  always_comb
  begin
    case (cmd_r)
      pmc_pkg::CMD_EXT_TEMP_GAIN: rd_word = ext_temp_gain_r;
      pmc_pkg::CMD_EXT_TEMP_BIAS: rd_word = ext_temp_bias_r;
      pmc_pkg::CMD_OUT_CEILING: rd_word = strapped_output_ceiling_r;
      pmc_pkg::CMD_SENSE_COEF: rd_word = {pmc_pkg::READ_PAD, sense_temp_coefficient_r};
      pmc_pkg::CMD_GAP_TIMES: rd_word = switch_gap_times_r;
      pmc_pkg::CMD_GAP_SETUP: rd_word = switch_gap_setup_r;
      pmc_pkg::CMD_RAIL_ORDER: rd_word = rail_order_links_r;
      default: rd_word = {pmc_pkg::READ_PAD, pmc_pkg::READ_PAD};
    endcase
  end
  assign tx_byte = (byte_idx_r == 2'h0) ? rd_word[7:0] :
                   (byte_idx_r == 2'h1) ? rd_word[15:8] : pmc_pkg::READ_PAD;
  assign bit_sel = 3'h7 - bit_cnt_r[2:0];

  // byte framing, acknowledge and bit transmit
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= pmc_pkg::PMC_IDLE;
      phase_r <= pmc_pkg::PMC_PH_ADDR;
      bit_cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      rd_mode_r <= 1'b0;
      cmd_have_r <= 1'b0;
      cmd_r <= 8'h00;
      byte_idx_r <= 2'h0;
      wbuf_r <= 16'h0000;
      sda_drive_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (stop_det)
      begin
        state_r <= pmc_pkg::PMC_IDLE;
        phase_r <= pmc_pkg::PMC_PH_ADDR;
        cmd_have_r <= 1'b0;
        rd_mode_r <= 1'b0;
        sda_drive_r <= 1'b0;
      end
      else if (start_det)
      begin
        state_r <= pmc_pkg::PMC_RX; // repeated start keeps the command
        phase_r <= pmc_pkg::PMC_PH_ADDR;
        bit_cnt_r <= 4'h0;
        rd_mode_r <= 1'b0;
        sda_drive_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          pmc_pkg::PMC_IDLE:
            sda_drive_r <= 1'b0;
          pmc_pkg::PMC_RX:
            if (scl_rise && bit_cnt_r != 4'h8)
            begin
              shreg_r <= {shreg_r[6:0], pin_s2_r[0]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (scl_fall && bit_cnt_r == 4'h8)
            begin
              sda_drive_r <= ack_now;
              state_r <= ack_now ? pmc_pkg::PMC_ACK : pmc_pkg::PMC_IDLE;
              if (ack_now)
              begin
                case (phase_r)
                  pmc_pkg::PMC_PH_ADDR:
                  begin
                    rd_mode_r <= shreg_r[0];
                    byte_idx_r <= 2'h0;
                    phase_r <= pmc_pkg::PMC_PH_CMD;
                  end
                  pmc_pkg::PMC_PH_CMD:
                  begin
                    cmd_r <= shreg_r;
                    cmd_have_r <= 1'b1;
                    byte_idx_r <= 2'h0;
                    phase_r <= pmc_pkg::PMC_PH_DATA;
                  end
                  default:
                  begin
                    if (byte_idx_r == 2'h0)
                      wbuf_r[7:0] <= shreg_r;
                    else
                      wbuf_r[15:8] <= shreg_r;
                    byte_idx_r <= byte_idx_r + 2'h1;
                  end
                endcase
              end
            end
          pmc_pkg::PMC_ACK:
            if (scl_fall)
            begin
              bit_cnt_r <= rd_mode_r ? 4'h1 : 4'h0;
              sda_drive_r <= rd_mode_r & ~tx_byte[7];
              state_r <= rd_mode_r ? pmc_pkg::PMC_TX : pmc_pkg::PMC_RX;
            end
          pmc_pkg::PMC_TX:
            if (scl_fall)
            begin
              if (bit_cnt_r == 4'h8)
              begin
                sda_drive_r <= 1'b0;
                state_r <= pmc_pkg::PMC_MACK;
              end
              else
              begin
                sda_drive_r <= ~tx_byte[bit_sel];
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          pmc_pkg::PMC_MACK:
            if (scl_rise)
            begin
              state_r <= pin_s2_r[0] ? pmc_pkg::PMC_IDLE : pmc_pkg::PMC_ACK;
              byte_idx_r <= byte_idx_r + 2'h1;
            end
          default:
            state_r <= pmc_pkg::PMC_IDLE;
        endcase
      end
    end
  end

  // a write takes effect at stop once the full length arrived
  assign wr_commit = ce_i && stop_det && phase_r == pmc_pkg::PMC_PH_DATA && !rd_mode_r &&
                     cmd_writable(cmd_r) && byte_idx_r == cmd_len(cmd_r);

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1_r <= pmc_pkg::WORD_RESET;
      strap_s2_r <= pmc_pkg::WORD_RESET;
      strap_cnt_r <= 2'h0;
      strapped_output_ceiling_r <= pmc_pkg::WORD_RESET;
    end
    else if (ce_i)
    begin
      strap_s1_r <= strap_vout_max_i;
      strap_s2_r <= strap_s1_r;
      if (strap_cnt_r != pmc_pkg::STRAP_SETTLE)
      begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
        strapped_output_ceiling_r <= strap_s2_r;
      end
    end
  end

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  // gain and bias are raw linear words, read back only
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_temp_gain_r <= pmc_pkg::WORD_RESET;
      ext_temp_bias_r <= pmc_pkg::WORD_RESET;
      sense_temp_coefficient_r <= pmc_pkg::BYTE_RESET;
      switch_gap_times_r <= pmc_pkg::WORD_RESET;
      switch_gap_setup_r <= pmc_pkg::WORD_RESET;
      rail_order_links_r <= pmc_pkg::WORD_RESET;
    end
    else if (wr_commit)
    begin
      case (cmd_r)
        pmc_pkg::CMD_EXT_TEMP_GAIN: ext_temp_gain_r <= wbuf_r;
        pmc_pkg::CMD_EXT_TEMP_BIAS: ext_temp_bias_r <= wbuf_r;
        pmc_pkg::CMD_SENSE_COEF: sense_temp_coefficient_r <= wbuf_r[7:0];
        pmc_pkg::CMD_GAP_TIMES: switch_gap_times_r <= wbuf_r;
        pmc_pkg::CMD_GAP_SETUP: switch_gap_setup_r <= wbuf_r;
        pmc_pkg::CMD_RAIL_ORDER: rail_order_links_r <= wbuf_r;
        default: ext_temp_gain_r <= ext_temp_gain_r;
      endcase
    end
  end

  // remembers a gap write as the last completed command
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      gap_pending_r <= 1'b0;
    else if (ce_i && stop_det && cmd_have_r)
      gap_pending_r <= wr_commit && cmd_r == pmc_pkg::CMD_GAP_TIMES;
  end

  // adaptive ceiling per edge
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      gap_max_r <= {pmc_pkg::GAP_MAX_DEFAULT_NS, pmc_pkg::GAP_MAX_DEFAULT_NS};
    else if (wr_commit && cmd_r == pmc_pkg::CMD_GAP_SETUP && gap_pending_r)
      gap_max_r <= switch_gap_times_r;
  end

  // ------------------------------------------------------------
  // dead-time resolve, index 1 high-to-low, 0 low-to-high
  // ------------------------------------------------------------
  assign adapt_ns = {adapt_hl_ns_i, adapt_lh_ns_i};

  for (genvar g = 0; g < 2; g++)
  begin : g_edge
    localparam int GAP_LSB = (g == 1) ? pmc_pkg::GAP_HL_LSB : pmc_pkg::GAP_LH_LSB;
    localparam int MIN_LSB = (g == 1) ? pmc_pkg::MIN_HL_LSB : pmc_pkg::MIN_LH_LSB;
    localparam int FRZ_BIT = (g == 1) ? pmc_pkg::FREEZE_HL_BIT : pmc_pkg::FREEZE_LH_BIT;
    pmc_gap_resolve u_resolve (
      .gap_ns_i(switch_gap_times_r[GAP_LSB +: pmc_pkg::GAP_W]),
      .min_code_i(switch_gap_setup_r[MIN_LSB +: pmc_pkg::MIN_W]),
      .max_ns_i(gap_max_r[g]),
      .freeze_i(switch_gap_setup_r[FRZ_BIT]),
      .adapt_ns_i(adapt_ns[g]),
      .applied_ns_o(applied_nxt[g])
    );
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      applied_r <= {pmc_pkg::BYTE_RESET, pmc_pkg::BYTE_RESET};
    else if (ce_i)
      applied_r <= applied_nxt;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign sda_o = 1'b0; // open drain, only ever pulls low
  assign sda_oe_o = sda_drive_r;
  assign dt_hl_ns_o = applied_r[1];
  assign dt_lh_ns_o = applied_r[0];
  assign dt_hl_frozen_o = switch_gap_setup_r[pmc_pkg::FREEZE_HL_BIT];
  assign dt_lh_frozen_o = switch_gap_setup_r[pmc_pkg::FREEZE_LH_BIT];
  assign sense_temp_coef_o = sense_temp_coefficient_r;
  assign prequel_en_o = rail_order_links_r[pmc_pkg::RAIL_PRE_EN_BIT];
  assign prequel_id_o = rail_order_links_r[pmc_pkg::RAIL_PRE_ID_LSB +: pmc_pkg::RAIL_ID_W];
  assign sequel_en_o = rail_order_links_r[pmc_pkg::RAIL_SEQ_EN_BIT];
  assign sequel_id_o = rail_order_links_r[pmc_pkg::RAIL_SEQ_ID_LSB +: pmc_pkg::RAIL_ID_W];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_gap_pair;
    gap_pending_r && wr_commit && cmd_r == pmc_pkg::CMD_GAP_SETUP;
  endsequence

  sequence s_gap_write;
    wr_commit && cmd_r == pmc_pkg::CMD_GAP_TIMES;
  endsequence

  a_max_default_sixty: assert property ($rose(rst_n) |-> gap_max_r[1] == 8'h3c && gap_max_r[0] == 8'h3c)
    else $error("adaptive maximum not sixty after reset");
  a_gap_pair_max: assert property (s_gap_pair |=> gap_max_r == $past(switch_gap_times_r))
    else $error("gap pair did not load maximum");
  a_gap_write_arms: assert property (s_gap_write |=> gap_pending_r ##0 switch_gap_times_r == $past(wbuf_r))
    else $error("gap write did not arm or store");
  a_frozen_uses_word: assert property (ce_i && switch_gap_setup_r[15] |=> dt_hl_ns_o == $past(switch_gap_times_r[15:8]))
    else $error("frozen high edge not using stored word");
  a_adapt_low_clamp: assert property (ce_i && !switch_gap_setup_r[7] && $signed(adapt_lh_ns_i) < $signed({switch_gap_setup_r[6:0], 1'b0})
                                      && $signed({switch_gap_setup_r[6:0], 1'b0}) <= $signed(gap_max_r[0])
                                      |=> dt_lh_ns_o == $past({switch_gap_setup_r[6:0], 1'b0}))
    else $error("low edge minimum not applied");
  a_ceiling_held: assert property (strap_cnt_r == 2'h3 |=> $stable(strapped_output_ceiling_r))
    else $error("ceiling changed after strap capture");
  a_ceiling_nack: assert property (ce_i && state_r == pmc_pkg::PMC_RX && scl_fall && bit_cnt_r == 4'h8
                                   && phase_r == pmc_pkg::PMC_PH_DATA && cmd_r == pmc_pkg::CMD_OUT_CEILING
                                   |=> !sda_oe_o && state_r == pmc_pkg::PMC_IDLE)
    else $error("write to ceiling acknowledged");
  a_rail_write: assert property (wr_commit && cmd_r == pmc_pkg::CMD_RAIL_ORDER
                                 |=> prequel_id_o == $past(wbuf_r[12:8]) && sequel_en_o == $past(wbuf_r[7]))
    else $error("rail order write lost");
  a_coef_write: assert property (wr_commit && cmd_r == pmc_pkg::CMD_SENSE_COEF |=> sense_temp_coef_o == $past(wbuf_r[7:0]))
    else $error("coefficient write lost");

endmodule : pmc_cfg_regs

// File: pmc_host_model.sv
// serial-bus host model driving clock and data of the config block
`timescale 1ns/10ps
module pmc_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // bus idles released, clock high
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // wait n falling clock edges
  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tk
  // one bit: data set mid low phase, held through the high phase
  task automatic bit_x(input logic b, output logic s);
    tk(4);
    sda_oe_o = ~b;
    tk(4);
    scl_o = 1'b1;
    tk(6);
    s = sda_i;
    tk(2);
    scl_o = 1'b0;
  endtask : bit_x
  // start or repeated start
  task automatic start();
    tk(4);
    sda_oe_o = 1'b0;
    tk(4);
    scl_o = 1'b1;
    tk(8);
    sda_oe_o = 1'b1;
    tk(8);
    scl_o = 1'b0;
  endtask : start
  // stop, bus left idle
  task automatic stop();
    tk(4);
    sda_oe_o = 1'b1;
    tk(4);
    scl_o = 1'b1;
    tk(8);
    sda_oe_o = 1'b0;
    tk(8);
  endtask : stop
  // byte out msb first, returns device acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask : wbyte
  // byte in, host acknowledges when m is high
  task automatic rbyte(output logic [7:0] b, input logic m);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(~m, s);
  endtask : rbyte
endmodule : pmc_host_model

// File: pol_mfr_config_registers_bench.sv
// self-checking bench of the config command registers
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin error_cnt++; $display("BAD %s exp=%h got=%h", nm, e, g); end end
module pol_mfr_config_registers_bench;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, scl, h_oe, d_oe, sda_o, hl_fz, lh_fz, pre_en, seq_en;
  logic [15:0] strap = 16'h0000, rl = 16'h0000, r, v, obs_w, exp_w;
  logic [7:0] a_hl = 8'h00, a_lh = 8'h00, dt_hl, dt_lh, coef;
  logic [4:0] pre_id, seq_id;
  logic [3:0] a;
  logic [7:0] cmds [3] = '{8'hd9, 8'hda, 8'he0};
  logic [15:0] exp_q [$];
  int error_cnt = 0, n_checks = 0, seed = 32'h01b3;
  string obs_nm;
  event obs_ev;
  wire sda = ~(h_oe | d_oe); // open drain with pull-up
  // ------------------------------------------------------------
  // clock, design, host
  // ------------------------------------------------------------
  initial forever #5 clk = ~clk;
  pmc_cfg_regs dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(d_oe), .strap_vout_max_i(strap), .adapt_hl_ns_i(a_hl), .adapt_lh_ns_i(a_lh),
    .dt_hl_ns_o(dt_hl), .dt_lh_ns_o(dt_lh), .dt_hl_frozen_o(hl_fz), .dt_lh_frozen_o(lh_fz),
    .sense_temp_coef_o(coef), .prequel_en_o(pre_en), .prequel_id_o(pre_id), .sequel_en_o(seq_en),
    .sequel_id_o(seq_id));
  pmc_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
  // ------------------------------------------------------------
  // notes, monitor, verdict
  // ------------------------------------------------------------
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    obs_nm = nm;
    obs_w = g;
    ->obs_ev;
    #1;
  endtask : cmp
  // oldest note against each observed result
  initial forever
  begin
    @(obs_ev);
    exp_w = exp_q.pop_front();
    `CHK(obs_nm, exp_w, obs_w)
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // watchdog
  initial
  begin
    #400us;
    error_cnt++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // bus transactions
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
    host.start();
    host.wbyte({pmc_pkg::DEV_ADDR_DEFAULT, 1'b0}, a[0]);
    host.wbyte(c, a[1]);
    host.wbyte(d[7:0], a[2]);
    a[3] = 1'b0;
    if (n > 1) host.wbyte(d[15:8], a[3]);
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    host.start();
    host.wbyte({pmc_pkg::DEV_ADDR_DEFAULT, 1'b0}, a[0]);
    host.wbyte(c, a[1]);
    host.start();
    host.wbyte({pmc_pkg::DEV_ADDR_DEFAULT, 1'b1}, a[2]);
    host.rbyte(d[7:0], 1'b1);
    host.rbyte(d[15:8], 1'b0);
    host.stop();
  endtask : rd
  // applied dead times after inputs settle
  task automatic dt(input logic [7:0] hl, input logic [7:0] lh, input logic [7:0] ahl, input logic [7:0] alh);
    a_hl = ahl;
    a_lh = alh;
    repeat (6) @(negedge clk);
    cmp("dead times", {hl, lh}, {dt_hl, dt_lh});
  endtask : dt
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    strap = 16'($random(seed));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    rd(pmc_pkg::CMD_OUT_CEILING, r);
    cmp("ceiling", strap, r);
    dt(8'h3c, 8'h3c, 8'h50, 8'h7f);
    foreach (cmds[i])
    begin
      v = 16'($random(seed));
      wr(cmds[i], v, 2);
      rd(cmds[i], r);
      cmp("word", v, r);
      // rail outputs follow the last rail word only
      if (cmds[i] == pmc_pkg::CMD_RAIL_ORDER)
        rl = v;
      cmp("rail links", {4'h0, rl[15], rl[12:8], rl[7], rl[4:0]}, {4'h0, pre_en, pre_id, seq_en, seq_id});
    end
    v = 16'($random(seed));
    wr(pmc_pkg::CMD_SENSE_COEF, v, 2);
    cmp("coef acks", 16'h0007, {12'h000, a});
    rd(pmc_pkg::CMD_SENSE_COEF, r);
    cmp("coef", {8'hff, v[7:0]}, r);
    cmp("coef out", {8'h00, v[7:0]}, {8'h00, coef});
    wr(pmc_pkg::CMD_OUT_CEILING, ~strap, 2);
    cmp("ceiling acks", 16'h0003, {12'h000, a});
    rd(pmc_pkg::CMD_OUT_CEILING, r);
    cmp("ceiling kept", strap, r);
    wr(8'hdf, v, 2);
    cmp("unmapped acks", 16'h0001, {12'h000, a});
    wr(pmc_pkg::CMD_GAP_SETUP, 16'h0a05, 2);
    dt(8'h14, 8'h0a, 8'h05, 8'h02);
    cmp("frozen", 16'h0000, {13'h0, sda_o, hl_fz, lh_fz});
    wr(pmc_pkg::CMD_GAP_SETUP, 16'h7b7b, 2);
    dt(8'hf6, 8'hf6, 8'hec, 8'hec);
    wr(pmc_pkg::CMD_GAP_TIMES, 16'h2814, 2);
    wr(pmc_pkg::CMD_GAP_SETUP, 16'h0000, 2);
    dt(8'h28, 8'h14, 8'h50, 8'h50);
    wr(pmc_pkg::CMD_GAP_TIMES, 16'h3232, 2);
    rd(pmc_pkg::CMD_RAIL_ORDER, r);
    wr(pmc_pkg::CMD_GAP_SETUP, 16'h0000, 2);
    dt(8'h28, 8'h14, 8'h50, 8'h50);
    wr(pmc_pkg::CMD_GAP_TIMES, 16'hf63c, 2);
    wr(pmc_pkg::CMD_GAP_SETUP, 16'h8080, 2);
    dt(8'hf6, 8'h3c, 8'h00, 8'h00);
    cmp("frozen", 16'h0003, {14'h0, hl_fz, lh_fz});
    wr(pmc_pkg::CMD_GAP_SETUP, 16'h8000, 2);
    dt(8'hf6, 8'h20, 8'h00, 8'h20);
    // clock enable low holds the applied times
    ce = 1'b0;
    a_lh = 8'h10;
    repeat (6) @(negedge clk);
    cmp("held by enable", {8'hf6, 8'h20}, {dt_hl, dt_lh});
    ce = 1'b1;
    dt(8'hf6, 8'h10, 8'h00, 8'h10);
    rd(pmc_pkg::CMD_GAP_TIMES, r);
    cmp("gap word", 16'hf63c, r);
    // second reset restores the maximum and recaptures the strap
    strap = 16'($random(seed));
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    dt(8'h3c, 8'h3c, 8'h50, 8'h50);
    rd(pmc_pkg::CMD_OUT_CEILING, r);
    cmp("ceiling again", strap, r);
    print_verdict();
  end
endmodule : pol_mfr_config_registers_bench
